// ===== gma_pkg.sv
/*
 * Shared definitions of the generic address memory unit.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package gma_pkg;

   // ****************************************************************
   // Widths and fixed positions
   // ****************************************************************
   localparam int unsigned ADDR_W    = 64;
   localparam int unsigned DATA_W    = 128;
   localparam int unsigned DW_W      = 32;
   localparam int unsigned APER_W    = 16;
   localparam int unsigned APER_LSB  = 48;  // Aperture tag field position.
   localparam int unsigned NUM_AOP   = 13;  // Atomic functions per width.

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [3:0]  RST_BE    = 4'h0;
   localparam logic [1:0]  RST_BEAT  = 2'h0;
   localparam logic        RST_RDY   = 1'b1;

   // ****************************************************************
   // Operations; the two atomic groups must stay in the same order.
   // ****************************************************************
   typedef enum logic [5:0] {
      OP_LD_U8, OP_LD_I8, OP_LD_U16, OP_LD_I16,
      OP_LD_B32, OP_LD_B64, OP_LD_B96, OP_LD_B128,
      OP_ST_B8, OP_ST_B16, OP_ST_B32, OP_ST_B64, OP_ST_B96, OP_ST_B128,
      OP_LD_LO_U8, OP_LD_LO_I8, OP_LD_LO_B16,
      OP_UPPER_HALF_BYTE_LOAD, OP_LD_HI_I8, OP_LD_HI_B16,
      OP_UPPER_HALF_BYTE_STORE, OP_ST_HI_B16,
      OP_AT_SWAP, OP_AT_CMPSWAP, OP_AT_ADD, OP_AT_SUB,
      OP_AT_SMIN, OP_AT_UMIN, OP_AT_SMAX, OP_AT_UMAX,
      OP_AT_AND, OP_AT_OR, OP_AT_XOR,
      OP_ATOMIC_WRAP_INCREMENT, OP_ATOMIC_WRAP_DECREMENT,
      OP_AT64_SWAP, OP_COMPARE_SWAP_64, OP_AT64_ADD, OP_AT64_SUB,
      OP_AT64_SMIN, OP_AT64_UMIN, OP_AT64_SMAX, OP_AT64_UMAX,
      OP_AT64_AND, OP_AT64_OR, OP_AT64_XOR,
      OP_AT64_INC, OP_AT64_DEC
   } gma_op_t;

   typedef enum logic [3:0] {
      AOP_SWAP, AOP_CMPSWAP, AOP_ADD, AOP_SUB,
      AOP_SMIN, AOP_UMIN, AOP_SMAX, AOP_UMAX,
      AOP_AND, AOP_OR, AOP_XOR, AOP_INC, AOP_DEC
   } gma_aop_t;

   typedef enum logic [1:0] {
      SPC_GLOBAL, SPC_PRIVATE, SPC_SCRATCH
   } gma_space_t;

   typedef enum logic [1:0] {
      ST_IDLE, ST_RD, ST_EXEC, ST_WR
   } gma_state_t;

endpackage : gma_pkg

// ===== gma_atomic_alu.sv
/*
 * Read-modify-write logic for 32-bit and 64-bit atomics.
 * Assumes the caller holds the location locked while the result is used.
 */
`timescale 1ns/1ps
module gma_atomic_alu (
   input  wire gma_pkg::gma_aop_t aop_i,
   input  wire logic              is64_i,
   input  wire logic [63:0]       old_i,
   input  wire logic [63:0]       src_i,
   input  wire logic [63:0]       cmp_i,
   output logic      [63:0]       new_o,
   output logic                   wr_o
);
   import gma_pkg::*;

   logic [63:0] a;
   logic [63:0] b;
   logic [63:0] c;
   logic        sx;

   // Widen 32-bit operands so one 64-bit datapath serves both sizes;
   // signed forms sign-extend, all others zero-extend.
   always_comb begin
      sx = (aop_i == AOP_SMIN) || (aop_i == AOP_SMAX);
      if (is64_i) begin
         a = old_i;
         b = src_i;
         c = cmp_i;
      end else begin
         a = {{32{sx & old_i[31]}}, old_i[31:0]};
         b = {{32{sx & src_i[31]}}, src_i[31:0]};
         c = {32'h0, cmp_i[31:0]};
      end
   end

   // New memory value; a failed compare or an unlisted function suppresses the write.
   always_comb begin
      wr_o = 1'b1;
      case (aop_i)
         AOP_SWAP:    new_o = b;
         AOP_CMPSWAP: begin
            new_o = b;
            wr_o  = (a == c);
         end
         AOP_ADD:     new_o = a + b;
         AOP_SUB:     new_o = a - b;
         AOP_SMIN:    new_o = ($signed(b) < $signed(a)) ? b : a;
         AOP_UMIN:    new_o = (b < a) ? b : a;
         AOP_SMAX:    new_o = ($signed(b) > $signed(a)) ? b : a;
         AOP_UMAX:    new_o = (b > a) ? b : a;
         AOP_AND:     new_o = a & b;
         AOP_OR:      new_o = a | b;
         AOP_XOR:     new_o = a ^ b;
         AOP_INC:     new_o = (a >= b) ? 64'h0 : a + 64'h1;
         AOP_DEC:     new_o = ((a == 64'h0) || (a > b)) ? b
                              : a - 64'h1;
         default:     begin
            new_o = a;
            wr_o  = 1'b0;
         end
      endcase
   end

endmodule : gma_atomic_alu

// ===== gma_mem_unit.sv
/*
 * Per-lane generic address memory unit: classifies the address space,
 * runs loads, stores and atomics as dword beats to the memory path and
 * returns formatted data to the issue side.
 * Assumes one request at a time, a dword memory port acking each beat
 * for one cycle, and a memory path that blocks other masters while
 * the lock output is high.
 */
//
// Overview of operation
// - Classify each lane address as global, private or scratch.
// - Unsigned byte and halfword loads zero-fill upper bits.
// - Signed byte and halfword loads sign-extend to 32 bits.
// - Multi-dword loads fill slices lowest first from offsets 0,4,8,12.
// - Multi-dword stores write slices lowest first at offsets 0,4,8,12.
// - Byte and halfword stores touch only their own bytes.
// - Low-half loads write bits 15..0, keep 31..16.
// - High-half loads write bits 31..16, keep 15..0.
// - High-half stores take byte 23..16 or halfword 31..16.
// - Swap writes the operand and returns the old value.
// - 32-bit compare-swap: new in 31..0, compare in 63..32.
// - Add and subtract update memory and return the old value.
// - Signed and unsigned min and max store the choice, return old.
// - AND, OR, XOR store the bitwise result, return old.
// - Wrap increment stores zero if old >= operand, else old plus one.
// - Wrap decrement stores operand if old is zero or above it.
// - 64-bit atomics act like 32-bit ones on 64-bit values.
// - 64-bit compare-swap: new in 63..0, compare in 127..64.
// - 64-bit compare-swap writes back only the first two dwords.
//
`timescale 1ns/1ps
module gma_mem_unit (
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   req_valid_i,
   output logic                        req_ready_o,
   input  wire gma_pkg::gma_op_t       req_op_i,
   input  wire logic [63:0]            req_addr_i,
   input  wire logic [127:0]           req_data_i,
   input  wire logic [31:0]            req_dest_i,
   input  wire logic [15:0]            aper_private_i,
   input  wire logic [15:0]            aper_scratch_i,
   output logic                        mem_req_o,
   output logic                        mem_we_o,
   output logic [3:0]                  mem_be_o,
   output logic [63:0]                 mem_addr_o,
   output logic [31:0]                 mem_wdata_o,
   output gma_pkg::gma_space_t         mem_space_o,
   output logic                        mem_lock_o,
   input  wire logic                   mem_ack_i,
   input  wire logic [31:0]            mem_rdata_i,
   output logic                        rsp_valid_o,
   output logic [127:0]                rsp_data_o,
   output logic [3:0]                  rsp_dw_mask_o
);
   import gma_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      gma_state_t         st;
      gma_op_t            op;
      logic [63:0]        addr;
      logic [127:0]       data;
      logic [31:0]        dest;
      logic [1:0]         beat;
      logic [3:0][31:0]   rbuf;
      gma_space_t         spc;
      logic               rdy;
      logic               mreq;
      logic               mwe;
      logic [3:0]         mbe;
      logic [63:0]        maddr;
      logic [31:0]        mwdata;
      logic               lock;
      logic               rvld;
      logic [127:0]       rdata;
      logic [3:0]         rmask;
   } gma_regs_t;

   gma_regs_t r_ff;
   gma_regs_t nxt_r;

   // ****************************************************************
   // Decoding helpers
   // ****************************************************************

   // Atomics sit at the end of the operation list, 32-bit group first.
   function automatic logic is_atomic(input gma_op_t op);
      is_atomic = (op >= OP_AT_SWAP);
   endfunction : is_atomic

   function automatic logic is_at64(input gma_op_t op);
      is_at64 = (op >= OP_AT64_SWAP);
   endfunction : is_at64

   function automatic gma_aop_t aop_of(input gma_op_t op);
      logic [5:0] idx;
      idx = 6'(op) - 6'(OP_AT_SWAP);
      if (is_at64(op)) begin
         idx = idx - 6'(NUM_AOP);
      end
      aop_of = gma_aop_t'(idx[3:0]);
   endfunction : aop_of

   function automatic logic is_store(input gma_op_t op);
      is_store = ((op >= OP_ST_B8) && (op <= OP_ST_B128))
                 || (op == OP_UPPER_HALF_BYTE_STORE)
                 || (op == OP_ST_HI_B16);
   endfunction : is_store

   // Index of the last dword beat of an operation.
   function automatic logic [1:0] last_beat(input gma_op_t op);
      case (op)
         OP_LD_B64, OP_ST_B64:   last_beat = 2'h1;
         OP_LD_B96, OP_ST_B96:   last_beat = 2'h2;
         OP_LD_B128, OP_ST_B128: last_beat = 2'h3;
         default:                last_beat = is_at64(op) ? 2'h1 : 2'h0;
      endcase
   endfunction : last_beat

   // Dword-aligned beat address: lane address plus 0, 4, 8 or 12.
   function automatic logic [63:0] beat_addr(input logic [63:0] a,
                                             input logic [1:0]  b);
      beat_addr = {a[63:2], 2'b00} + {60'h0, b, 2'b00};
   endfunction : beat_addr

   // Top address bits select the space.
   function automatic gma_space_t classify(input logic [63:0] a,
                                           input logic [15:0] pb,
                                           input logic [15:0] sb);
      if (a[63:APER_LSB] == pb) begin
         classify = SPC_PRIVATE;
      end else if (a[63:APER_LSB] == sb) begin
         classify = SPC_SCRATCH;
      end else begin
         classify = SPC_GLOBAL;
      end
   endfunction : classify

   // Byte enables and replicated data for one store beat.
   function automatic logic [35:0] store_lane(input gma_op_t      op,
                                              input logic [1:0]   lo,
                                              input logic [127:0] d,
                                              input logic [1:0]   b);
      logic [3:0] be;
      be = 4'h1 << lo;
      case (op)
         OP_ST_B8:      store_lane = {be, {4{d[7:0]}}};
         OP_ST_B16:     store_lane = {lo[1] ? 4'hc : 4'h3,
                                      {2{d[15:0]}}};
         OP_UPPER_HALF_BYTE_STORE:
                        store_lane = {be, {4{d[23:16]}}};
         OP_ST_HI_B16:  store_lane = {lo[1] ? 4'hc : 4'h3,
                                      {2{d[31:16]}}};
         default:       store_lane = {4'hf, d[32*b +: 32]};
      endcase
   endfunction : store_lane

   // Formats a finished load and its dword mask.
   function automatic logic [131:0] load_fmt(input gma_op_t          op,
                                             input logic [1:0]       lo,
                                             input logic [3:0][31:0] rb,
                                             input logic [31:0]      dst);
      logic [7:0]  by;
      logic [15:0] hw;
      by = 8'(rb[0] >> {lo, 3'b000});
      hw = lo[1] ? rb[0][31:16] : rb[0][15:0];
      case (op)
         OP_LD_U8:   load_fmt = {4'h1, 96'h0, 24'h0, by};
         OP_LD_U16:  load_fmt = {4'h1, 96'h0, 16'h0, hw};
         OP_LD_I8:   load_fmt = {4'h1, 96'h0, {24{by[7]}}, by};
         OP_LD_I16:  load_fmt = {4'h1, 96'h0, {16{hw[15]}}, hw};
         OP_LD_B32:  load_fmt = {4'h1, 96'h0, rb[0]};
         OP_LD_B64:  load_fmt = {4'h3, 64'h0, rb[1], rb[0]};
         OP_LD_B96:  load_fmt = {4'h7, 32'h0, rb[2], rb[1], rb[0]};
         OP_LD_B128: load_fmt = {4'hf, rb};
         OP_LD_LO_U8:
            load_fmt = {4'h1, 96'h0, dst[31:16], 8'h0, by};
         OP_LD_LO_I8:
            load_fmt = {4'h1, 96'h0, dst[31:16], {8{by[7]}}, by};
         OP_LD_LO_B16:
            load_fmt = {4'h1, 96'h0, dst[31:16], hw};
         OP_UPPER_HALF_BYTE_LOAD:
            load_fmt = {4'h1, 96'h0, 8'h0, by, dst[15:0]};
         OP_LD_HI_I8:
            load_fmt = {4'h1, 96'h0, {8{by[7]}}, by, dst[15:0]};
         OP_LD_HI_B16:
            load_fmt = {4'h1, 96'h0, hw, dst[15:0]};
         default:    load_fmt = {4'h0, 128'h0};
      endcase
   endfunction : load_fmt

   // ****************************************************************
   // Atomic datapath
   // ****************************************************************
   logic        at64;
   logic [63:0] alu_src;
   logic [63:0] alu_cmp;
   logic [63:0] alu_new;
   logic        alu_wr;

   // Operand fields: compare value sits above the new value.
   assign at64    = is_at64(r_ff.op);
   assign alu_src = at64 ? r_ff.data[63:0]
                         : {32'h0, r_ff.data[31:0]};
   assign alu_cmp = at64 ? r_ff.data[127:64]
                         : {32'h0, r_ff.data[63:32]};

   gma_atomic_alu u_alu (
      .aop_i  (aop_of(r_ff.op)),
      .is64_i (at64),
      .old_i  ({r_ff.rbuf[1], r_ff.rbuf[0]}),
      .src_i  (alu_src),
      .cmp_i  (alu_cmp),
      .new_o  (alu_new),
      .wr_o   (alu_wr)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // The beat counter walks the dwords; the memory request stays high
   // until the last ack.
   always_comb begin
      nxt_r      = r_ff;
      nxt_r.rvld = 1'b0;
      case (r_ff.st)
         ST_IDLE: begin
            if (req_valid_i) begin
               nxt_r.op    = req_op_i;
               nxt_r.addr  = req_addr_i;
               nxt_r.data  = req_data_i;
               nxt_r.dest  = req_dest_i;
               nxt_r.beat  = RST_BEAT;
               nxt_r.rdy   = 1'b0;
               nxt_r.spc   = classify(req_addr_i, aper_private_i,
                                      aper_scratch_i);
               nxt_r.mreq  = 1'b1;
               nxt_r.maddr = beat_addr(req_addr_i, RST_BEAT);
               // Lock is raised with the first read of an atomic.
               nxt_r.lock  = is_atomic(req_op_i);
               if (is_store(req_op_i)) begin
                  nxt_r.st  = ST_WR;
                  nxt_r.mwe = 1'b1;
                  {nxt_r.mbe, nxt_r.mwdata} =
                     store_lane(req_op_i, req_addr_i[1:0], req_data_i,
                                RST_BEAT);
               end else begin
                  nxt_r.st  = ST_RD;
                  nxt_r.mwe = 1'b0;
                  nxt_r.mbe = 4'hf;
               end
            end
         end
         ST_RD: begin
            if (mem_ack_i) begin
               nxt_r.rbuf[r_ff.beat] = mem_rdata_i;
               if (r_ff.beat == last_beat(r_ff.op)) begin
                  nxt_r.mreq = 1'b0;
                  if (is_atomic(r_ff.op)) begin
                     nxt_r.st = ST_EXEC;
                  end else begin
                     {nxt_r.rmask, nxt_r.rdata} =
                        load_fmt(r_ff.op, r_ff.addr[1:0], nxt_r.rbuf,
                                 r_ff.dest);
                     nxt_r.rvld = 1'b1;
                     nxt_r.rdy  = 1'b1;
                     nxt_r.st   = ST_IDLE;
                  end
               end else begin
                  nxt_r.beat  = r_ff.beat + 2'h1;
                  nxt_r.maddr = beat_addr(r_ff.addr, nxt_r.beat);
               end
            end
         end
         ST_EXEC: begin
            // Old value goes back; a 64-bit result only fills two dwords.
            if (at64) begin
               nxt_r.rdata = {64'h0, r_ff.rbuf[1], r_ff.rbuf[0]};
               nxt_r.rmask = 4'h3;
            end else begin
               nxt_r.rdata = {96'h0, r_ff.rbuf[0]};
               nxt_r.rmask = 4'h1;
            end
            if (alu_wr) begin
               nxt_r.data[63:0] = alu_new;
               nxt_r.st         = ST_WR;
               nxt_r.beat       = RST_BEAT;
               nxt_r.mreq       = 1'b1;
               nxt_r.mwe        = 1'b1;
               nxt_r.mbe        = 4'hf;
               nxt_r.mwdata     = alu_new[31:0];
               nxt_r.maddr      = beat_addr(r_ff.addr, RST_BEAT);
            end else begin
               // A failed compare ends without touching memory.
               nxt_r.lock = 1'b0;
               nxt_r.rvld = 1'b1;
               nxt_r.rdy  = 1'b1;
               nxt_r.st   = ST_IDLE;
            end
         end
         ST_WR: begin
            if (mem_ack_i) begin
               if (r_ff.beat == last_beat(r_ff.op)) begin
                  nxt_r.mreq = 1'b0;
                  nxt_r.mwe  = 1'b0;
                  nxt_r.mbe  = RST_BE;
                  // On the write path, lock falls only after the last write is accepted.
                  nxt_r.lock = 1'b0;
                  nxt_r.rvld = 1'b1;
                  nxt_r.rdy  = 1'b1;
                  nxt_r.st   = ST_IDLE;
                  if (!is_atomic(r_ff.op)) begin
                     nxt_r.rmask = 4'h0;
                  end
               end else begin
                  nxt_r.beat  = r_ff.beat + 2'h1;
                  nxt_r.maddr = beat_addr(r_ff.addr, nxt_r.beat);
                  {nxt_r.mbe, nxt_r.mwdata} =
                     store_lane(r_ff.op, r_ff.addr[1:0], r_ff.data,
                                nxt_r.beat);
               end
            end
         end
         default: begin
            nxt_r.st  = ST_IDLE;
            nxt_r.rdy = RST_RDY;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // All clears to idle except ready, which resets high.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r_ff     <= '0;
         r_ff.rdy <= RST_RDY;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign req_ready_o   = r_ff.rdy;
   assign mem_req_o     = r_ff.mreq;
   assign mem_we_o      = r_ff.mwe;
   assign mem_be_o      = r_ff.mbe;
   assign mem_addr_o    = r_ff.maddr;
   assign mem_wdata_o   = r_ff.mwdata;
   assign mem_space_o   = r_ff.spc;
   assign mem_lock_o    = r_ff.lock;
   assign rsp_valid_o   = r_ff.rvld;
   assign rsp_data_o    = r_ff.rdata;
   assign rsp_dw_mask_o = r_ff.rmask;

endmodule : gma_mem_unit

// ===== gma_mem_unit_assertions.sv
/* Port checker for gma_mem_unit, bound into every instance.
   Assumes gma_pkg and the unit's one-request-at-a-time contract. */
`timescale 1ns/1ps
module gma_mem_unit_chk
   import gma_pkg::*;
(
   input wire logic       clk_sys_i, rst_b_i, req_valid_i, req_ready_o,
   input wire gma_op_t    req_op_i,
   input wire logic [63:0] req_addr_i, mem_addr_o,
   input wire logic [15:0] aper_private_i, aper_scratch_i,
   input wire logic       mem_req_o, mem_we_o, mem_lock_o, mem_ack_i,
   input wire logic       rsp_valid_o,
   input wire logic [3:0] mem_be_o, rsp_dw_mask_o,
   input wire gma_space_t mem_space_o
);
   // ****************************************************************
   // Request capture
   // ****************************************************************
   gma_op_t     op_ff;
   logic [63:0] adr_ff;
   gma_space_t  spc_ff;
   // Private wins a double tag match.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_ff  <= OP_LD_U8;
         adr_ff <= 64'h0;
         spc_ff <= SPC_GLOBAL;
      end else if (req_valid_i && req_ready_o) begin
         op_ff  <= req_op_i;
         adr_ff <= req_addr_i;
         spc_ff <= (req_addr_i[63:48] == aper_private_i) ? SPC_PRIVATE :
                   (req_addr_i[63:48] == aper_scratch_i) ? SPC_SCRATCH :
                   SPC_GLOBAL;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   space_match_a: assert property (mem_req_o |-> mem_space_o == spc_ff)
      else $error("address space wrong");
   first_beat_a: assert property (req_valid_i && req_ready_o |=> mem_req_o
      && mem_addr_o == {adr_ff[63:2], 2'b00}) else $error("first beat wrong");
   beat_step_a: assert property (mem_req_o && mem_ack_i ##1 mem_req_o
      |-> mem_addr_o == $past(mem_addr_o) + 64'h4) else $error("beat step");
   hold_beat_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
      && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("beat moved");
   byte_lane_a: assert property (mem_req_o && op_ff == OP_ST_B8 |->
      mem_we_o && mem_be_o == (4'h1 << adr_ff[1:0])) else $error("byte lane");
   lock_held_a: assert property (mem_req_o && op_ff >= OP_AT_SWAP
      |-> mem_lock_o) else $error("atomic beat unlocked");
   lock_free_a: assert property (rsp_valid_o |-> !mem_lock_o && req_ready_o
      ##1 !rsp_valid_o) else $error("completion wrong");
   cas64_mask_a: assert property (rsp_valid_o && op_ff == OP_COMPARE_SWAP_64
      |-> rsp_dw_mask_o == 4'h3) else $error("wide compare mask");
   wide_mask_a: assert property (rsp_valid_o && op_ff == OP_LD_B96
      |-> rsp_dw_mask_o == 4'h7) else $error("three dword mask");
   cover property (rsp_valid_o && op_ff == OP_COMPARE_SWAP_64);
   cover property (mem_req_o && mem_space_o == SPC_SCRATCH);
   cover property (mem_req_o && !mem_ack_i [*2]);
endmodule : gma_mem_unit_chk

bind gma_mem_unit gma_mem_unit_chk chk (.clk_sys_i, .rst_b_i, .req_valid_i,
   .req_ready_o, .req_op_i, .req_addr_i, .mem_addr_o, .aper_private_i,
   .aper_scratch_i, .mem_req_o, .mem_we_o, .mem_lock_o, .mem_ack_i,
   .rsp_valid_o, .mem_be_o, .rsp_dw_mask_o, .mem_space_o);

// ===== gma_mem_model.sv
/* Behavioural memory path: 16 dwords, byte enables, one ack per beat.
   Assumes a single master and a bench that presets the array. */
`timescale 1ns/1ps
module gma_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  be_i,
   input  wire logic [63:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [1:0]  wait_i,
   output logic             ack_o,
   output logic [31:0]      rdata_o
);
   logic [31:0] mem [0:15];
   logic [1:0]  cnt;
   initial begin
      ack_o = 1'b0;
      rdata_o = 32'h0;
      cnt = 2'h0;
   end
   // Read data toggles outside the ack cycle, so a late sample shows.
   always @(posedge clk_sys_i) begin
      rdata_o <= ~rdata_o;
      ack_o <= 1'b0;
      if (req_i && !ack_o && cnt == wait_i) begin
         ack_o <= 1'b1;
         cnt <= 2'h0;
         if (!we_i) rdata_o <= mem[addr_i[5:2]];
         for (int b = 0; b < 4; b++)
            if (we_i && be_i[b]) mem[addr_i[5:2]][8*b +: 8] <= wdata_i[8*b +: 8];
      end else if (req_i && !ack_o) cnt <= cnt + 2'h1;
   end
endmodule : gma_mem_model

// ===== gma_mem_unit_tb.sv
/* Self-checking bench for gma_mem_unit against the behavioural memory.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module gma_mem_unit_tb;
   import gma_pkg::*;
   logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0;
   gma_op_t     req_op_i = OP_LD_U8;
   logic [63:0] req_addr_i = 64'h0, mem_addr_o;
   logic [127:0] req_data_i = 128'h0, rsp_data_o, got;
   logic [31:0] req_dest_i = 32'h0, mem_wdata_o, mem_rdata_i;
   logic        req_ready_o, mem_req_o, mem_we_o, mem_lock_o, mem_ack_i;
   logic        rsp_valid_o;
   logic [3:0]  mem_be_o, rsp_dw_mask_o;
   gma_space_t  mem_space_o;
   logic [1:0]  wt = 2'h0;
   int          miscompares = 0, comparisons = 0;
   localparam logic [63:0] PA = 64'h1111_0000_0000_0000;
   localparam logic [63:0] SA = 64'h2222_0000_0000_0000;
   always #50 clk_sys_i = ~clk_sys_i;
   gma_mem_unit dut (.clk_sys_i, .rst_b_i, .req_valid_i, .req_ready_o,
      .req_op_i, .req_addr_i, .req_data_i, .req_dest_i,
      .aper_private_i(16'h1111), .aper_scratch_i(16'h2222), .mem_req_o,
      .mem_we_o, .mem_be_o, .mem_addr_o, .mem_wdata_o, .mem_space_o,
      .mem_lock_o, .mem_ack_i, .mem_rdata_i, .rsp_valid_o, .rsp_data_o,
      .rsp_dw_mask_o);
   gma_mem_model mdl (.clk_sys_i, .req_i(mem_req_o), .we_i(mem_we_o),
      .be_i(mem_be_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .wait_i(wt), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic c64(input logic [63:0] g, e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : c64
   // One request, held until taken; both waits are bounded.
   task automatic op(input gma_op_t o, input logic [63:0] a,
                     input logic [127:0] d, input logic [31:0] dst);
      int n;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b1;
      req_op_i <= o;
      req_addr_i <= a;
      req_data_i <= d;
      req_dest_i <= dst;
      n = 0;
      do begin @(posedge clk_sys_i); n++; end
      while (req_ready_o !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      req_valid_i <= 1'b0;
      n = 0;
      do begin @(posedge clk_sys_i); n++; end
      while (rsp_valid_o !== 1'b1 && n < 60);
      if (n >= 60) begin miscompares++; conclude(); end
      got = rsp_data_o;
   endtask : op
   task automatic ld(input gma_op_t o, input logic [63:0] a,
                     input logic [31:0] dst, input logic [31:0] e);
      op(o, a, 128'h0, dst);
      c64({32'h0, got[31:0]}, {32'h0, e});
   endtask : ld
   task automatic t_loads;
      mdl.mem[0] = 32'h8c7b_f2a9;
      mdl.mem[1] = 32'h1111_2222;
      mdl.mem[2] = 32'h3333_4444;
      ld(OP_LD_U8, PA + 64'h3, 32'h0, 32'h0000_008c);
      ld(OP_LD_I8, PA + 64'h3, 32'h0, 32'hffff_ff8c);
      ld(OP_LD_U16, 64'h2, 32'h0, 32'h0000_8c7b);
      ld(OP_LD_I16, SA + 64'h2, 32'h0, 32'hffff_8c7b);
      ld(OP_LD_LO_I8, 64'h0, 32'h1234_5678, 32'h1234_ffa9);
      ld(OP_UPPER_HALF_BYTE_LOAD, 64'h1, 32'h1234_5678, 32'h00f2_5678);
      ld(OP_LD_HI_B16, 64'h2, 32'h1234_5678, 32'h8c7b_5678);
      op(OP_LD_B96, SA, 128'h0, 32'h0);
      c64(got[63:0], 64'h1111_2222_8c7b_f2a9);
      c64(got[127:64] & 64'hffff_ffff, 64'h3333_4444);
      $display("loads done");
   endtask : t_loads
   task automatic t_stores;
      mdl.mem[8] = 32'hffff_ffff;
      mdl.mem[9] = 32'h0;
      op(OP_ST_B128, 64'h10, 128'h4444_4444_3333_3333_2222_2222_1111_1111, 0);
      c64({mdl.mem[5], mdl.mem[4]}, 64'h2222_2222_1111_1111);
      c64({mdl.mem[7], mdl.mem[6]}, 64'h4444_4444_3333_3333);
      op(OP_ST_B8, 64'h22, 128'h5a, 32'h0);
      c64(mdl.mem[8], 64'hff5a_ffff);
      op(OP_UPPER_HALF_BYTE_STORE, 64'h21, 128'h00c3_0000, 32'h0);
      c64(mdl.mem[8], 64'hff5a_c3ff);
      op(OP_ST_HI_B16, 64'h26, 128'hbeef_0000, 32'h0);
      c64(mdl.mem[9], 64'hbeef_0000);
      $display("stores done");
   endtask : t_stores
   function automatic logic [63:0] nw(input int k, input logic [63:0] o,
                                      input logic [63:0] s, c);
      case (k)
         0: return s;
         1: return (o == c) ? s : o;
         2: return o + s;
         3: return o - s;
         4: return ($signed(s) < $signed(o)) ? s : o;
         5: return (s < o) ? s : o;
         6: return ($signed(s) > $signed(o)) ? s : o;
         7: return (s > o) ? s : o;
         8: return o & s;
         9: return o | s;
         10: return o ^ s;
         11: return (o >= s) ? 64'h0 : o + 64'h1;
         default: return (o == 64'h0 || o > s) ? s : o - 64'h1;
      endcase
   endfunction : nw
   // 32-bit runs compare only the low dword of result and memory.
   task automatic t_atomics(input bit w);
      logic [63:0] o, s, c, m;
      m = w ? '1 : 64'hffff_ffff;
      o = w ? 64'h8000_0001_ffff_fffe : 64'hffff_ffff_8000_0005;
      s = w ? 64'h3 : 64'h7;
      for (int k = 0; k < 13; k++) begin
         c = (w && k == 1) ? 64'h1 : o;
         wt <= k[1:0];
         {mdl.mem[7], mdl.mem[6]} = o;
         op(gma_op_t'((w ? OP_AT64_SWAP : OP_AT_SWAP) + k), 64'h18,
            w ? {c, s} : {64'h0, c[31:0], s[31:0]}, 32'h0);
         c64(got[63:0] & m, o & m);
         c64({mdl.mem[7], mdl.mem[6]} & m, nw(k, o, s, c) & m);
      end
      $display("atomics done");
   endtask : t_atomics
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_loads();
      t_stores();
      t_atomics(1'b0);
      t_atomics(1'b1);
      conclude();
   end
endmodule : gma_mem_unit_tb
